/* sim/cdim_regs_bench.sv */
// Purpose: self-checking bench for cdim_regs
// Assumes: zero-wait APB slave, default reference divider code
// Notes: a watcher scores each APB answer against a queue of notes
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module cdim_regs_bench;
    reg clk_sys, resetn, psel, penable, pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    reg [3:0] pstrb;
    reg left_input_path_on, right_input_path_on;
    wire [31:0] prdata;
    wire pready, pslverr, ref_clock_tick, debounce_tick, timeout_tick, gp_output_clock_tick;
    wire left_boost_mixer_mute, right_boost_mixer_mute, left_boost_mixer_on;
    wire right_boost_mixer_on, left_input_amp_on, right_input_amp_on;
    wire [2:0] left_second_input_gain, left_third_input_gain, left_amp_to_mixer_gain;
    wire [2:0] right_second_input_gain, right_third_input_gain, right_amp_to_mixer_gain;
    wire left_second_input_select, left_third_input_select, left_amp_path_select;
    wire right_second_input_select, right_third_input_select, right_amp_path_select;
    wire [2:0] boost_mixer_bias_level, input_amp_bias_level;
    wire [8:0] lg_o = {left_second_input_gain, left_amp_to_mixer_gain, left_third_input_gain};
    wire [8:0] rg_o = {right_second_input_gain, right_amp_to_mixer_gain, right_third_input_gain};
    wire [5:0] sel_o = {left_second_input_select, left_third_input_select, left_amp_path_select,
        right_second_input_select, right_third_input_select, right_amp_path_select};
    wire [5:0] bias_o = {boost_mixer_bias_level, input_amp_bias_level};
    logic [33:0] exp_q[$];
    logic [33:0] exp_now;
    logic [15:0] seed, rl, rr, rs, rb;
    int fail_count = 0;
    int n_checks = 0;
    int i, n;
    int gp_tab[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    logic [15:0] rst_tab[6] = '{16'h005E, 16'h0000, 16'h0145, 16'h0145, 16'h0009, 16'h0004};
    logic [2:0] mb_tab[3] = '{3'h0, 3'h3, 3'h4};

    cdim_regs cdim_regs_inst (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .left_input_path_on, .right_input_path_on,
        .ref_clock_tick, .debounce_tick, .timeout_tick, .gp_output_clock_tick,
        .left_boost_mixer_mute, .right_boost_mixer_mute, .left_boost_mixer_on,
        .right_boost_mixer_on, .left_input_amp_on, .right_input_amp_on,
        .left_second_input_gain, .left_third_input_gain, .left_amp_to_mixer_gain,
        .right_second_input_gain, .right_third_input_gain, .right_amp_to_mixer_gain,
        .left_second_input_select, .left_third_input_select, .left_amp_path_select,
        .right_second_input_select, .right_third_input_select, .right_amp_path_select,
        .boost_mixer_bias_level, .input_amp_bias_level);

    ////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one transfer, entered just after a rising edge; note is {write, err, data}
    task apb(input bit w, input [7:0] a, input [15:0] d, input [3:0] s, input [33:0] e);
        int k;
        exp_q.push_back(e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {~d, d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'h1;
        k = 0;
        do begin @(posedge clk_sys); k++; end while (pready !== 1'h1 && k < 8);
        if (pready !== 1'h1) begin fail_count++; final_report; end
    endtask

    task wr(input [7:0] a, input [15:0] d);
        apb(1'h1, a, d, 4'hF, {2'h2, 32'h0});
    endtask

    task rd(input [7:0] a, input [31:0] x);
        apb(1'h0, a, 16'h0000, 4'hF, {2'h0, x});
    endtask

    task idle;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask

    // release the bus and let outputs follow
    task settle;
        idle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    function logic tick_of(input int w);
        case (w)
            0: tick_of = ref_clock_tick;
            1: tick_of = debounce_tick;
            2: tick_of = timeout_tick;
            default: tick_of = gp_output_clock_tick;
        endcase
    endfunction

    // cycles from one tick to the next
    task period(input int w, input int lim, output int p);
        int k;
        k = 0;
        do begin @(negedge clk_sys); k++; end while (tick_of(w) !== 1'h1 && k < lim);
        if (k >= lim) begin fail_count++; final_report; end
        p = 0;
        do begin @(negedge clk_sys); p++; end while (tick_of(w) !== 1'h1 && p < lim);
        if (p >= lim) begin fail_count++; final_report; end
        @(posedge clk_sys);
    endtask

    function logic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    // scores each answer in its access cycle
    always @(posedge clk_sys) begin
        if (resetn && psel && penable && pready) begin
            if (exp_q.size() == 0) begin
                `CHK("queue", 1'h1, 1'h0)
            end else begin
                exp_now = exp_q.pop_front();
                `CHK("pslverr", exp_now[32], pslverr)
                if (!exp_now[33]) `CHK("prdata", exp_now[31:0], prdata)
            end
        end
    end

    ////////////////////////////////////////
    initial begin
        {resetn, psel, penable, pwrite, left_input_path_on, right_input_path_on} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        seed = 16'h001D;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        for (i = 0; i < 6; i++) rd(8'h78 + 8'(4 * i), {16'h0000, rst_tab[i]});
        settle;
        `CHK("lgain", 9'h145, lg_o)
        `CHK("rgain", 9'h145, rg_o)
        `CHK("sel", 6'h09, sel_o)
        `CHK("bias", 6'h04, bias_o)
        @(posedge clk_sys);
        $display("test reset done");
        apb(1'h0, 8'h90, 16'h0000, 4'hF, {2'h1, 32'h0});
        apb(1'h1, 8'h74, 16'hFFFF, 4'hF, {2'h3, 32'h0});
        wr(8'h78, 16'hFFFF);
        rd(8'h78, 32'h0000FFDE);
        wr(8'h78, 16'h1C80);
        rd(8'h78, 32'h00001CDE);
        idle;
        $display("test refusals done");
        for (i = 0; i < 64; i++) begin
            wr(8'h7C, 16'(i & 15));
            rd(8'h7C, 32'(i & 15));
            left_input_path_on <= i[4];
            right_input_path_on <= i[5];
            settle;
            `CHK("mute", i[3:2], {left_boost_mixer_mute, right_boost_mixer_mute})
            `CHK("lon", i[1] | i[4], left_boost_mixer_on)
            `CHK("ron", i[0] | i[5], right_boost_mixer_on)
            `CHK("amp", {i[4], i[5]}, {left_input_amp_on, right_input_amp_on})
            @(posedge clk_sys);
        end
        $display("test mute enable done");
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            rl = seed;
            seed = lfsr(seed);
            rr = seed;
            seed = lfsr(seed);
            rs = seed;
            wr(8'h80, rl);
            wr(8'h84, rr);
            wr(8'h88, rs);
            rb = {10'h000, mb_tab[i % 3], (i[0] ? 3'h4 : 3'h0)};
            wr(8'h8C, rb);
            rd(8'h84, {23'h0, rr[8:0]});
            rd(8'h88, {26'h0, rs[5:0]});
            settle;
            `CHK("lgain", rl[8:0], lg_o)
            `CHK("rgain", rr[8:0], rg_o)
            `CHK("sel", rs[5:0], sel_o)
            `CHK("bias", rb[5:0], bias_o)
            @(posedge clk_sys);
        end
        apb(1'h1, 8'h80, 16'hFFFF, 4'h1, {2'h2, 32'h0});
        rd(8'h80, {23'h0, rl[8], 8'hFF});
        idle;
        $display("test fields done");
        for (i = 0; i < 8; i++) begin
            wr(8'h78, 16'(i << 10) | 16'h0080);
            idle;
            period(3, 64, n);
            `CHK("gp period", gp_tab[i], n)
        end
        period(0, 200, n);
        `CHK("ref period", 48, n)
        period(1, 30000, n);
        `CHK("debounce period", 12288, n)
        period(2, 30000, n);
        `CHK("timeout period", 24576, n)
        $display("test dividers done");
        final_report;
    end
endmodule // cdim_regs_bench

bind cdim_regs cdim_regs_monitor #(.REF_DIV_CODE(REF_DIV_CODE)) cdim_regs_monitor_inst (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .left_input_path_on, .right_input_path_on, .ref_clock_tick, .left_boost_mixer_mute,
    .right_boost_mixer_mute, .left_boost_mixer_on, .right_boost_mixer_on,
    .left_input_amp_on, .right_input_amp_on, .left_second_input_gain,
    .left_third_input_gain, .left_amp_to_mixer_gain, .right_second_input_gain,
    .right_third_input_gain, .right_amp_to_mixer_gain);

/* sim/cdim_regs_monitor.sv */
// Purpose: port-level checks for cdim_regs
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top
`timescale 1ns/1ps

module cdim_regs_monitor #(
    parameter [5:0] REF_DIV_CODE = 6'h2F
) (
    input wire clk_sys,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire left_input_path_on,
    input wire right_input_path_on,
    input wire ref_clock_tick,
    input wire left_boost_mixer_mute,
    input wire right_boost_mixer_mute,
    input wire left_boost_mixer_on,
    input wire right_boost_mixer_on,
    input wire left_input_amp_on,
    input wire right_input_amp_on,
    input wire [2:0] left_second_input_gain,
    input wire [2:0] left_third_input_gain,
    input wire [2:0] left_amp_to_mixer_gain,
    input wire [2:0] right_second_input_gain,
    input wire [2:0] right_third_input_gain,
    input wire [2:0] right_amp_to_mixer_gain
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire wr_done = psel && penable && pready && pwrite;
    reg [6:0] gap_r;
    reg seen_r;

    // cycles since the last reference tick
    always @(posedge clk_sys) begin
        if (!resetn || ref_clock_tick) begin
            gap_r <= 7'h00;
        end else begin
            gap_r <= gap_r + 7'h01;
        end
        if (!resetn) begin
            seen_r <= 1'h0;
        end else if (ref_clock_tick) begin
            seen_r <= 1'h1;
        end
    end

    ////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_left_path_on: assert property (left_input_path_on |=> left_boost_mixer_on)
        else $error("left path did not enable mixer");
    a_right_path_on: assert property (right_input_path_on |=> right_boost_mixer_on)
        else $error("right path did not enable mixer");
    a_amp_follows_path: assert property (1'h1 |=>
        left_input_amp_on == $past(left_input_path_on)
        && right_input_amp_on == $past(right_input_path_on)) else $error("amp enable off path");
    a_ref_tick_gap: assert property (ref_clock_tick && seen_r |-> gap_r == REF_DIV_CODE)
        else $error("reference tick spacing wrong");
    a_ref_gap_bound: assert property (seen_r |-> gap_r <= REF_DIV_CODE)
        else $error("reference tick missing");
    a_mute_on_write: assert property ($past(resetn) &&
        $changed({left_boost_mixer_mute, right_boost_mixer_mute}) |->
        $past(wr_done, 1) || $past(wr_done, 2)) else $error("mute moved without write");
    a_gain_on_write: assert property ($past(resetn) && $changed({left_second_input_gain,
        left_third_input_gain, left_amp_to_mixer_gain, right_second_input_gain,
        right_third_input_gain, right_amp_to_mixer_gain}) |->
        $past(wr_done, 1) || $past(wr_done, 2)) else $error("gain moved without write");
endmodule // cdim_regs_monitor

/* src/cdim_map.vh */
// Purpose: register map, field positions, reset values and write masks for cdim_regs
// Assumes: APB word addressing, byte address is four times the register index
// Notes: definitions only
`ifndef CDIM_MAP_VH
`define CDIM_MAP_VH

// register indices as printed, byte address is index times four
`define CDIM_IDX_CLOCK_DIVIDER_CONFIG 6'h1E
`define CDIM_IDX_INPUT_MIXER_MUTE_ENABLE 6'h1F
`define CDIM_IDX_LEFT_MIXER_GAIN 6'h20
`define CDIM_IDX_RIGHT_MIXER_GAIN 6'h21
`define CDIM_IDX_INPUT_MIXER_SOURCE_SELECT 6'h22
`define CDIM_IDX_INPUT_BIAS_SELECT 6'h23

// clock_divider_config fields
`define CDIM_DBDIV_MSB 15
`define CDIM_DBDIV_LSB 13
`define CDIM_GPDIV_MSB 12
`define CDIM_GPDIV_LSB 10
`define CDIM_TODIV_MSB 9
`define CDIM_TODIV_LSB 7
`define CDIM_REFDIV_MSB 6
`define CDIM_REFDIV_LSB 1
`define CDIM_REFDIV_RESET 6'h2F
`define CDIM_CLKCFG_WR_MASK 16'hFF80

// input_mixer_mute_enable fields
`define CDIM_LMUTE_BIT 3
`define CDIM_RMUTE_BIT 2
`define CDIM_LON_BIT 1
`define CDIM_RON_BIT 0
`define CDIM_MUTEEN_MASK 16'h000F

// mixer gain fields, same layout for left and right
`define CDIM_GAIN2_LSB 6
`define CDIM_GAINAMP_LSB 3
`define CDIM_GAIN3_LSB 0
`define CDIM_GAIN_MASK 16'h01FF
`define CDIM_GAIN_RESET 16'h0145

// source select fields
`define CDIM_LSEL2_BIT 5
`define CDIM_LSEL3_BIT 4
`define CDIM_LSELAMP_BIT 3
`define CDIM_RSEL2_BIT 2
`define CDIM_RSEL3_BIT 1
`define CDIM_RSELAMP_BIT 0
`define CDIM_SEL_MASK 16'h003F
`define CDIM_SEL_RESET 16'h0009

// bias fields
`define CDIM_MIXBIAS_LSB 3
`define CDIM_AMPBIAS_LSB 0
`define CDIM_BIAS_MASK 16'h003F
`define CDIM_BIAS_RESET 16'h0004

`endif

/* src/cdim_regs.v */
// Purpose: clock divider and input boost mixer control register bank on APB
// Assumes: single clock clk_sys, synchronous active-low reset, path enables on same clock
// Notes: all divided rates are one-cycle enable pulses; unmapped addresses answer pslverr
//
// Behaviour
// - debounce tick divides reference by coded divisor
// - gp output tick divides system clock by coded divisor, 1 to 16
// - timeout tick divides reference, 256 to 32768
// - reference divider readback fixed, n+1, unwritable
// - mute bits mute left and right mixers
// - left mixer on by own bit or path
// - right mixer on by own bit or path
// - left direct input gains stored, reset 101
// - left amp-to-mixer gain stored, reset 000
// - right direct input gains stored, reset 101
// - right amp-to-mixer gain stored, reset 000
// - left source selects, amp path resets on
// - right source selects, amp path resets on
// - mixer bias field decoded, reserved codes unused
// - amp bias field decoded, reset 100
// - path enable turns on amp and mixer
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "cdim_map.vh"

module cdim_regs #(
    parameter ADDR_W = 8,
    parameter [5:0] REF_DIV_CODE = `CDIM_REFDIV_RESET
) (
    input wire clk_sys,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire left_input_path_on,
    input wire right_input_path_on,
    output reg ref_clock_tick,
    output reg debounce_tick,
    output reg timeout_tick,
    output reg gp_output_clock_tick,
    output reg left_boost_mixer_mute,
    output reg right_boost_mixer_mute,
    output reg left_boost_mixer_on,
    output reg right_boost_mixer_on,
    output reg left_input_amp_on,
    output reg right_input_amp_on,
    output reg [2:0] left_second_input_gain,
    output reg [2:0] left_third_input_gain,
    output reg [2:0] left_amp_to_mixer_gain,
    output reg [2:0] right_second_input_gain,
    output reg [2:0] right_third_input_gain,
    output reg [2:0] right_amp_to_mixer_gain,
    output reg left_second_input_select,
    output reg left_third_input_select,
    output reg left_amp_path_select,
    output reg right_second_input_select,
    output reg right_third_input_select,
    output reg right_amp_path_select,
    output reg [2:0] boost_mixer_bias_level,
    output reg [2:0] input_amp_bias_level
);

    ////////////////////////////////////////////////////////////////////////////
    // divisor lookups

    // debounce divisor, code 110 kept at its printed figure
    function [17:0] db_divisor;
        input [2:0] code;
        begin
            case (code)
                3'h0: db_divisor = 18'd256;
                3'h1: db_divisor = 18'd2048;
                3'h2: db_divisor = 18'd4096;
                3'h3: db_divisor = 18'd8192;
                3'h4: db_divisor = 18'd16384;
                3'h5: db_divisor = 18'd32768;
                3'h6: db_divisor = 18'd64536;
                default: db_divisor = 18'd131072;
            endcase
        end
    endfunction

    // timeout divisor, doubling from 256
    function [16:0] to_divisor;
        input [2:0] code;
        begin
            to_divisor = 17'd256 << code;
        end
    endfunction

    // gp output divisor, non-uniform steps
    function [4:0] gp_divisor;
        input [2:0] code;
        begin
            case (code)
                3'h0: gp_divisor = 5'd1;
                3'h1: gp_divisor = 5'd2;
                3'h2: gp_divisor = 5'd3;
                3'h3: gp_divisor = 5'd4;
                3'h4: gp_divisor = 5'd6;
                3'h5: gp_divisor = 5'd8;
                3'h6: gp_divisor = 5'd12;
                default: gp_divisor = 5'd16;
            endcase
        end
    endfunction

    // merge write data into a 16-bit register by byte lane and writable mask
    function [15:0] merge_wr;
        input [15:0] old;
        input [15:0] wdata;
        input [1:0] strb;
        input [15:0] mask;
        reg [15:0] lane;
        begin
            lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
            merge_wr = (old & ~lane) | (wdata & lane);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    reg [8:0] clk_cfg_r;
    reg [5:0] ref_div_r;
    reg [3:0] mute_en_r;
    reg [8:0] lgain_r;
    reg [8:0] rgain_r;
    reg [5:0] sel_r;
    reg [5:0] bias_r;

    // assembled 16-bit views for read and merge
    wire [15:0] clk_cfg_view;
    wire [15:0] mute_en_view;
    wire [15:0] lgain_view;
    wire [15:0] rgain_view;
    wire [15:0] sel_view;
    wire [15:0] bias_view;

    assign clk_cfg_view = {clk_cfg_r, ref_div_r, 1'b0};
    assign mute_en_view = {12'h000, mute_en_r};
    assign lgain_view = {7'h00, lgain_r};
    assign rgain_view = {7'h00, rgain_r};
    assign sel_view = {10'h000, sel_r};
    assign bias_view = {10'h000, bias_r};

    ////////////////////////////////////////////////////////////////////////////
    // apb address decode

    wire [5:0] word_idx;
    reg hit;
    reg [15:0] rd_mux;
    reg [5:0] wr_sel;

    assign word_idx = paddr[7:2];

    // one hit per register, unlisted bits read as zero
    always @* begin
        hit = 1'b1;
        rd_mux = 16'h0000;
        wr_sel = 6'h00;
        if (word_idx == `CDIM_IDX_CLOCK_DIVIDER_CONFIG) begin
            rd_mux = clk_cfg_view;
            wr_sel = 6'h01;
        end else if (word_idx == `CDIM_IDX_INPUT_MIXER_MUTE_ENABLE) begin
            rd_mux = mute_en_view;
            wr_sel = 6'h02;
        end else if (word_idx == `CDIM_IDX_LEFT_MIXER_GAIN) begin
            rd_mux = lgain_view;
            wr_sel = 6'h04;
        end else if (word_idx == `CDIM_IDX_RIGHT_MIXER_GAIN) begin
            rd_mux = rgain_view;
            wr_sel = 6'h08;
        end else if (word_idx == `CDIM_IDX_INPUT_MIXER_SOURCE_SELECT) begin
            rd_mux = sel_view;
            wr_sel = 6'h10;
        end else if (word_idx == `CDIM_IDX_INPUT_BIAS_SELECT) begin
            rd_mux = bias_view;
            wr_sel = 6'h20;
        end else begin
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb handshake, one wait-free access phase

    wire setup_ph;
    wire wr_go;

    assign setup_ph = psel & ~penable;
    assign wr_go = psel & penable & pready & pwrite & ~pslverr;

    // answer is prepared in the setup cycle, shown during the access cycle
    always @(posedge clk_sys) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= (pwrite | ~hit) ? 32'h0000_0000 : {16'h0000, rd_mux};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    wire [15:0] clk_cfg_nxt;
    wire [15:0] mute_en_nxt;
    wire [15:0] lgain_nxt;
    wire [15:0] rgain_nxt;
    wire [15:0] sel_nxt;
    wire [15:0] bias_nxt;

    assign clk_cfg_nxt = merge_wr(clk_cfg_view, pwdata[15:0], pstrb[1:0], `CDIM_CLKCFG_WR_MASK);
    assign mute_en_nxt = merge_wr(mute_en_view, pwdata[15:0], pstrb[1:0], `CDIM_MUTEEN_MASK);
    assign lgain_nxt = merge_wr(lgain_view, pwdata[15:0], pstrb[1:0], `CDIM_GAIN_MASK);
    assign rgain_nxt = merge_wr(rgain_view, pwdata[15:0], pstrb[1:0], `CDIM_GAIN_MASK);
    assign sel_nxt = merge_wr(sel_view, pwdata[15:0], pstrb[1:0], `CDIM_SEL_MASK);
    assign bias_nxt = merge_wr(bias_view, pwdata[15:0], pstrb[1:0], `CDIM_BIAS_MASK);

    // reset words, cut to the stored field widths below
    wire [15:0] gain_rst = `CDIM_GAIN_RESET;
    wire [15:0] sel_rst = `CDIM_SEL_RESET;
    wire [15:0] bias_rst = `CDIM_BIAS_RESET;

    // defaults at reset, writes take effect at the access edge
    always @(posedge clk_sys) begin
        if (!resetn) begin
            clk_cfg_r <= 9'h000;
            ref_div_r <= `CDIM_REFDIV_RESET;
            mute_en_r <= 4'h0;
            lgain_r <= gain_rst[8:0];
            rgain_r <= gain_rst[8:0];
            sel_r <= sel_rst[5:0];
            bias_r <= bias_rst[5:0];
        end else begin
            // readback follows the built-in divide code, never the bus
            ref_div_r <= REF_DIV_CODE;
            if (wr_go && wr_sel[0]) begin
                clk_cfg_r <= clk_cfg_nxt[15:7];
            end
            if (wr_go && wr_sel[1]) begin
                mute_en_r <= mute_en_nxt[3:0];
            end
            if (wr_go && wr_sel[2]) begin
                lgain_r <= lgain_nxt[8:0];
            end
            if (wr_go && wr_sel[3]) begin
                rgain_r <= rgain_nxt[8:0];
            end
            if (wr_go && wr_sel[4]) begin
                sel_r <= sel_nxt[5:0];
            end
            if (wr_go && wr_sel[5]) begin
                bias_r <= bias_nxt[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate dividers

    wire [2:0] db_code;
    wire [2:0] gp_code;
    wire [2:0] to_code;
    wire [16:0] db_limit;
    wire [16:0] to_limit;
    wire [4:0] gp_limit;
    wire ref_pulse;

    assign db_code = clk_cfg_view[`CDIM_DBDIV_MSB:`CDIM_DBDIV_LSB];
    assign gp_code = clk_cfg_view[`CDIM_GPDIV_MSB:`CDIM_GPDIV_LSB];
    assign to_code = clk_cfg_view[`CDIM_TODIV_MSB:`CDIM_TODIV_LSB];
    // largest divisor needs 18 bits, its terminal count fits in 17
    wire [17:0] db_full;
    assign db_full = db_divisor(db_code) - 18'd1;
    assign db_limit = db_full[16:0];
    assign to_limit = to_divisor(to_code) - 17'd1;
    assign gp_limit = gp_divisor(gp_code) - 5'd1;

    reg [5:0] ref_cnt_r;
    reg [16:0] db_cnt_r;
    reg [16:0] to_cnt_r;
    reg [4:0] gp_cnt_r;

    assign ref_pulse = (ref_cnt_r >= ref_div_r);

    // reference rate: system clock divided by code plus one
    always @(posedge clk_sys) begin
        if (!resetn) begin
            ref_cnt_r <= 6'h00;
            ref_clock_tick <= 1'b0;
        end else begin
            ref_cnt_r <= ref_pulse ? 6'h00 : ref_cnt_r + 6'h01;
            ref_clock_tick <= ref_pulse;
        end
    end

    // debounce and timeout rates count reference pulses
    always @(posedge clk_sys) begin
        if (!resetn) begin
            db_cnt_r <= 17'h00000;
            to_cnt_r <= 17'h00000;
            debounce_tick <= 1'b0;
            timeout_tick <= 1'b0;
        end else begin
            debounce_tick <= ref_pulse && (db_cnt_r >= db_limit);
            timeout_tick <= ref_pulse && (to_cnt_r >= to_limit);
            if (ref_pulse) begin
                db_cnt_r <= (db_cnt_r >= db_limit) ? 17'h00000 : db_cnt_r + 17'h00001;
                to_cnt_r <= (to_cnt_r >= to_limit) ? 17'h00000 : to_cnt_r + 17'h00001;
            end
        end
    end

    // gp output rate, divide by one gives a pulse every cycle
    always @(posedge clk_sys) begin
        if (!resetn) begin
            gp_cnt_r <= 5'h00;
            gp_output_clock_tick <= 1'b0;
        end else begin
            gp_output_clock_tick <= (gp_cnt_r >= gp_limit);
            gp_cnt_r <= (gp_cnt_r >= gp_limit) ? 5'h00 : gp_cnt_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mixer control outputs

    // enables and mutes, registered one cycle after their cause
    always @(posedge clk_sys) begin
        if (!resetn) begin
            left_boost_mixer_mute <= 1'b0;
            right_boost_mixer_mute <= 1'b0;
            left_boost_mixer_on <= 1'b0;
            right_boost_mixer_on <= 1'b0;
            left_input_amp_on <= 1'b0;
            right_input_amp_on <= 1'b0;
        end else begin
            left_boost_mixer_mute <= mute_en_r[`CDIM_LMUTE_BIT];
            right_boost_mixer_mute <= mute_en_r[`CDIM_RMUTE_BIT];
            left_boost_mixer_on <= mute_en_r[`CDIM_LON_BIT] | left_input_path_on;
            right_boost_mixer_on <= mute_en_r[`CDIM_RON_BIT] | right_input_path_on;
            left_input_amp_on <= left_input_path_on;
            right_input_amp_on <= right_input_path_on;
        end
    end

    // gains, selects and bias levels follow their fields
    always @(posedge clk_sys) begin
        if (!resetn) begin
            left_second_input_gain <= 3'h5;
            left_third_input_gain <= 3'h5;
            left_amp_to_mixer_gain <= 3'h0;
            right_second_input_gain <= 3'h5;
            right_third_input_gain <= 3'h5;
            right_amp_to_mixer_gain <= 3'h0;
            left_second_input_select <= 1'b0;
            left_third_input_select <= 1'b0;
            left_amp_path_select <= 1'b1;
            right_second_input_select <= 1'b0;
            right_third_input_select <= 1'b0;
            right_amp_path_select <= 1'b1;
            boost_mixer_bias_level <= 3'h0;
            input_amp_bias_level <= 3'h4;
        end else begin
            left_second_input_gain <= lgain_r[`CDIM_GAIN2_LSB+2:`CDIM_GAIN2_LSB];
            left_third_input_gain <= lgain_r[`CDIM_GAIN3_LSB+2:`CDIM_GAIN3_LSB];
            left_amp_to_mixer_gain <= lgain_r[`CDIM_GAINAMP_LSB+2:`CDIM_GAINAMP_LSB];
            right_second_input_gain <= rgain_r[`CDIM_GAIN2_LSB+2:`CDIM_GAIN2_LSB];
            right_third_input_gain <= rgain_r[`CDIM_GAIN3_LSB+2:`CDIM_GAIN3_LSB];
            right_amp_to_mixer_gain <= rgain_r[`CDIM_GAINAMP_LSB+2:`CDIM_GAINAMP_LSB];
            left_second_input_select <= sel_r[`CDIM_LSEL2_BIT];
            left_third_input_select <= sel_r[`CDIM_LSEL3_BIT];
            left_amp_path_select <= sel_r[`CDIM_LSELAMP_BIT];
            right_second_input_select <= sel_r[`CDIM_RSEL2_BIT];
            right_third_input_select <= sel_r[`CDIM_RSEL3_BIT];
            right_amp_path_select <= sel_r[`CDIM_RSELAMP_BIT];
            boost_mixer_bias_level <= bias_r[`CDIM_MIXBIAS_LSB+2:`CDIM_MIXBIAS_LSB];
            input_amp_bias_level <= bias_r[`CDIM_AMPBIAS_LSB+2:`CDIM_AMPBIAS_LSB];
        end
    end

endmodule // cdim_regs
